// ---- src/ddc_top.v ----
// dual converter register control: byte registers, update logic, pin sharing
`timescale 1ns/1ps
`include "ddc_regs.vh"
module ddc_top (
	input  wire        mclk,
	input  wire        rst,
	input  wire [7:0]  sfr_addr,
	input  wire [7:0]  sfr_wdata,
	input  wire        sfr_wr,
	input  wire        sfr_rd,
	output wire [7:0]  sfr_rdata,
	output wire        sfr_hit,
	output wire [11:0] conv0_code,
	output wire [11:0] conv1_code,
	output wire        conv0_drive_n,
	output wire        conv1_drive_n,
	output wire        conv0_range_select,
	output wire        conv1_range_select,
	output wire        analog_input_4_avail,
	output wire        analog_input_5_avail
);
	wire [7:0] c0l;
	wire [7:0] c0h;
	wire [7:0] c1l;
	wire [7:0] c1h;
	wire [7:0] ctrl;
	wire       we_c0l  = sfr_wr & (sfr_addr == `DDC_ADDR_C0_LOW);
	wire       we_c0h  = sfr_wr & (sfr_addr == `DDC_ADDR_C0_HIGH);
	wire       we_c1l  = sfr_wr & (sfr_addr == `DDC_ADDR_C1_LOW);
	wire       we_c1h  = sfr_wr & (sfr_addr == `DDC_ADDR_C1_HIGH);
	wire       we_ctrl = sfr_wr & (sfr_addr == `DDC_ADDR_CTRL);

	ddc_byte_reg #(.RESET_VAL(`DDC_DATA_RESET)) u_c0l ( // RULE_12
		.mclk(mclk), .rst(rst), .wr_en(we_c0l), .wr_data(sfr_wdata), .q(c0l));
	ddc_byte_reg #(.RESET_VAL(`DDC_DATA_RESET)) u_c0h ( // RULE_12
		.mclk(mclk), .rst(rst), .wr_en(we_c0h), .wr_data(sfr_wdata), .q(c0h));
	ddc_byte_reg #(.RESET_VAL(`DDC_DATA_RESET)) u_c1l ( // RULE_12
		.mclk(mclk), .rst(rst), .wr_en(we_c1l), .wr_data(sfr_wdata), .q(c1l));
	ddc_byte_reg #(.RESET_VAL(`DDC_DATA_RESET)) u_c1h ( // RULE_12
		.mclk(mclk), .rst(rst), .wr_en(we_c1h), .wr_data(sfr_wdata), .q(c1h));
	ddc_byte_reg #(.RESET_VAL(`DDC_CTRL_RESET)) u_ctrl ( // RULE_11
		.mclk(mclk), .rst(rst), .wr_en(we_ctrl), .wr_data(sfr_wdata), .q(ctrl));

	wire mode8   = ctrl[`DDC_BIT_MODE];  // RULE_02
	wire async_r = ctrl[`DDC_BIT_ASYNC];

	// staged codes follow the stored bytes combinationally, in the same cycle the write lands
	wire [11:0] stage0 = mode8 ? {4'h0, c0l} : {c0h[3:0], c0l}; // RULE_13
	wire [11:0] stage1 = mode8 ? {4'h0, c1l} : {c1h[3:0], c1l}; // RULE_13

	// low byte write takes effect the cycle after it is stored
	reg  lw0_r;
	reg  lw1_r;
	reg  sync_go_r;
	always @(posedge mclk) begin
		if (rst) begin
			lw0_r     <= 1'b0;
			lw1_r     <= 1'b0;
			sync_go_r <= 1'b0;
		end else begin
			lw0_r     <= we_c0l;
			lw1_r     <= we_c1l;
			// rising edge of the update bit releases both staged codes
			sync_go_r <= we_ctrl & sfr_wdata[`DDC_BIT_ASYNC] & ~async_r; // RULE_08
		end
	end
	wire load0 = (async_r & lw0_r) | sync_go_r; // RULE_01 RULE_07 RULE_08
	wire load1 = (async_r & lw1_r) | sync_go_r; // RULE_07 RULE_08

	wire en0;
	wire en1;
	ddc_conv_out u_out0 (
		.mclk(mclk), .rst(rst), .load(load0), .code_in(stage0),
		.clear_n(ctrl[`DDC_BIT_CONV0_CLEAR_N]),     // RULE_06
		.power_up(ctrl[`DDC_BIT_PU0]),     // RULE_10
		.range_sel(ctrl[`DDC_BIT_CONV0_RANGE_SELECT]),   // RULE_04
		.code(conv0_code), .out_en(en0), .range(conv0_range_select));
	ddc_conv_out u_out1 (
		.mclk(mclk), .rst(rst), .load(load1), .code_in(stage1),
		.clear_n(ctrl[`DDC_BIT_CONV1_CLEAR_N]),     // RULE_05
		.power_up(ctrl[`DDC_BIT_PU1]),     // RULE_09
		.range_sel(ctrl[`DDC_BIT_CONV1_RANGE_SELECT]),   // RULE_03
		.code(conv1_code), .out_en(en1), .range(conv1_range_select));

	// powered-down converter leaves its pin undriven
	assign conv0_drive_n        = ~en0;  // RULE_16
	assign conv1_drive_n        = ~en1;  // RULE_16
	assign analog_input_4_avail = ~en0;  // RULE_15
	assign analog_input_5_avail = ~en1;  // RULE_15

	reg [7:0] rd_r;
	reg       hit_c;
	always @* begin
		hit_c = 1'b1;
		case (sfr_addr)
		`DDC_ADDR_C0_LOW:  rd_r = c0l;
		`DDC_ADDR_C0_HIGH: rd_r = c0h;
		`DDC_ADDR_C1_LOW:  rd_r = c1l;
		`DDC_ADDR_C1_HIGH: rd_r = c1h;
		`DDC_ADDR_CTRL:    rd_r = ctrl;
		default: begin
			rd_r  = 8'h00;
			hit_c = 1'b0;
		end
		endcase
	end
	assign sfr_rdata = sfr_rd ? rd_r : 8'h00; // RULE_17
	assign sfr_hit   = hit_c;
endmodule // ddc_top

// ---- inc/ddc_regs.vh ----
// register offsets, field positions, reset values for the dual converter control
// Summary of operation
// [RULE_01] 12-bit async: output takes new code when low byte written; write high first.
// [RULE_02] Control bit 7: 1 selects 8-bit mode using low byte, 0 selects 12-bit.
// [RULE_03] Control bit 6: converter 1 range, 1 analog supply, 0 reference range.
// [RULE_04] Control bit 5: converter 0 range, 1 analog supply, 0 reference range.
// [RULE_05] Control bit 4: converter 1 normal when 1, output forced to zero when 0.
// [RULE_06] Control bit 3: converter 0 normal when 1, output forced to zero when 0.
// [RULE_07] Control bit 2 set: each output updates when its low byte is written.
// [RULE_08] Bit 2 clear: writes held; both outputs update together when bit set.
// [RULE_09] Control bit 1: 1 powers converter 1 up, 0 powers it down.
// [RULE_10] Control bit 0: 1 powers converter 0 up, 0 powers it down.
// [RULE_11] Control register resets to 04H.
// [RULE_12] All four data byte registers reset to 00H.
// [RULE_13] 12-bit code right-justified: low byte bits 7:0, high nibble bits 11:8.
// [RULE_14] Software keeps the ADC powered whenever a converter uses reference range.
// [RULE_15] Converter outputs share pins with analog inputs 4 and 5.
// [RULE_16] After power-on both converters disabled, outputs high impedance until enabled.
// [RULE_17] Reads return last written value, or the reset value.
`ifndef DDC_REGS_VH
`define DDC_REGS_VH
`define DDC_ADDR_C0_LOW   8'hF9
`define DDC_ADDR_C0_HIGH  8'hFA
`define DDC_ADDR_C1_LOW   8'hFB
`define DDC_ADDR_C1_HIGH  8'hFC
`define DDC_ADDR_CTRL     8'hFD
`define DDC_CTRL_RESET    8'h04
`define DDC_DATA_RESET    8'h00
`define DDC_BIT_MODE      7
`define DDC_BIT_CONV1_RANGE_SELECT      6
`define DDC_BIT_CONV0_RANGE_SELECT      5
`define DDC_BIT_CONV1_CLEAR_N      4
`define DDC_BIT_CONV0_CLEAR_N      3
`define DDC_BIT_ASYNC     2
`define DDC_BIT_PU1       1
`define DDC_BIT_PU0       0
`endif

// ---- src/ddc_byte_reg.v ----
// one software byte register with reset value
`timescale 1ns/1ps
module ddc_byte_reg #(
	parameter [7:0] RESET_VAL = 8'h00
) (
	input  wire       mclk,
	input  wire       rst,
	input  wire       wr_en,
	input  wire [7:0] wr_data,
	output wire [7:0] q
);
	reg [7:0] q_r;
	always @(posedge mclk) begin
		if (rst)
			q_r <= RESET_VAL;
		else if (wr_en)
			q_r <= wr_data;
	end
	assign q = q_r;
endmodule // ddc_byte_reg

// ---- src/ddc_conv_out.v ----
// per-converter active code latch and analog control outputs
`timescale 1ns/1ps
module ddc_conv_out (
	input  wire        mclk,
	input  wire        rst,
	input  wire        load,
	input  wire [11:0] code_in,
	input  wire        clear_n,
	input  wire        power_up,
	input  wire        range_sel,
	output wire [11:0] code,
	output wire        out_en,
	output wire        range
);
	reg [11:0] act_r;
	reg        en_r;
	reg        clr_r;
	reg        rng_r;
	always @(posedge mclk) begin
		if (rst) begin
			act_r <= 12'h000;
			en_r  <= 1'b0;
			clr_r <= 1'b0;
			rng_r <= 1'b0;
		end else begin
			if (load)
				act_r <= code_in;
			en_r  <= power_up;
			clr_r <= clear_n;
			rng_r <= range_sel;
		end
	end
	// cleared converter drives code zero, i.e. 0 V
	assign code   = clr_r ? act_r : 12'h000;
	assign out_en = en_r;
	assign range  = rng_r;
endmodule // ddc_conv_out

// ---- sim/ddc_properties.sv ----
// port checks for the dual converter register control
`timescale 1ns/1ps
module ddc_properties (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [7:0]  sfr_addr,
	input wire logic [7:0]  sfr_wdata,
	input wire logic        sfr_wr,
	input wire logic        sfr_rd,
	input wire logic [7:0]  sfr_rdata,
	input wire logic        sfr_hit,
	input wire logic [11:0] conv0_code,
	input wire logic [11:0] conv1_code,
	input wire logic        conv0_drive_n,
	input wire logic        conv1_drive_n,
	input wire logic        conv0_range_select,
	input wire logic        conv1_range_select,
	input wire logic        analog_input_4_avail,
	input wire logic        analog_input_5_avail
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_ctl; sfr_wr && sfr_addr == 8'hFD; endsequence
	sequence s_rd_back; sfr_wr ##1 sfr_rd && sfr_addr == $past(sfr_addr); endsequence
	property p_pu; s_ctl |-> ##2 {conv1_drive_n, conv0_drive_n} == ~$past(sfr_wdata[1:0], 2);
	endproperty
	property p_rng; s_ctl |-> ##2 {conv1_range_select, conv0_range_select} == $past(sfr_wdata[6:5], 2);
	endproperty
	property p_conv0_clear_n; s_ctl ##0 !sfr_wdata[3] |-> ##2 conv0_code == 12'h000; endproperty
	property p_conv1_clear_n; s_ctl ##0 !sfr_wdata[4] |-> ##2 conv1_code == 12'h000; endproperty
	property p_avail; analog_input_4_avail == conv0_drive_n && analog_input_5_avail == conv1_drive_n;
	endproperty
	property p_hold; !$stable(conv0_code) || !$stable(conv1_code) |-> $past(sfr_wr, 2); endproperty
	property p_rd; s_rd_back |-> sfr_rdata == $past(sfr_wdata); endproperty
	property p_unm; sfr_rd && !sfr_hit |-> sfr_rdata == 8'h00; endproperty
	property p_rst; disable iff (1'b0) rst |=> conv0_drive_n && conv1_drive_n && conv0_code == 12'h000;
	endproperty
	a_pu: assert property (p_pu) else $error("power enable wrong");
	a_rng: assert property (p_rng) else $error("range wrong");
	a_conv0_clear_n: assert property (p_conv0_clear_n) else $error("clear 0 wrong");
	a_conv1_clear_n: assert property (p_conv1_clear_n) else $error("clear 1 wrong");
	a_avail: assert property (p_avail) else $error("pin sharing wrong");
	a_hold: assert property (p_hold) else $error("code moved unasked");
	a_rd: assert property (p_rd) else $error("readback wrong");
	a_unm: assert property (p_unm) else $error("unmapped read wrong");
	a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule // ddc_properties

// ---- sim/ddc_top_bench.sv ----
// self-checking bench for the dual converter register control
`timescale 1ns/1ps
module ddc_top_bench;
	logic mclk, rst, sfr_wr, sfr_rd, sfr_hit, conv0_drive_n, conv1_drive_n;
	logic conv0_range_select, conv1_range_select, analog_input_4_avail, analog_input_5_avail;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
	logic [11:0] conv0_code, conv1_code;
	int fail_count, samples_checked, cycles, i;
	ddc_top dut_u (.*);
	initial begin
		mclk = 0;
		forever #50 mclk = ~mclk;
	end
	task give_verdict;
		if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			give_verdict;
		end
	end
	task chk(input logic [11:0] s, input logic [11:0] e);
		samples_checked++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %0t %h %h", $time, s, e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk) #1 {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
		@(posedge mclk) #1 sfr_wr = 0;
	endtask
	// read stays enabled; value judged mid-cycle, address held over the next edge
	task rc(input logic [7:0] a, input logic [7:0] e);
		sfr_addr = a;
		#50 chk(sfr_rdata, e);
		cyc(1);
	endtask
	function logic [5:0] pins;
		return {conv1_range_select, conv0_range_select, conv1_drive_n, conv0_drive_n,
			analog_input_5_avail, analog_input_4_avail};
	endfunction
	initial begin
		{rst, sfr_rd, sfr_wr, sfr_addr, sfr_wdata} = {2'b11, 17'h0};
		cyc(5);
		rst = 0;
		rc(8'hFD, 8'h04);
		for (i = 0; i < 4; i++) rc(8'(8'hF9 + i), 8'h00);
		chk(pins(), 6'h0F);
		rc(8'hF8, 8'h00);
		chk(sfr_hit, 1'b0);
		rc(8'hFC, 8'h00);
		chk(sfr_hit, 1'b1);
		wr(8'hFD, 8'h1F);
		rc(8'hFD, 8'h1F);
		chk(pins(), 6'h00);
		wr(8'hFA, 8'h0A);
		cyc(2);
		chk(conv0_code, 12'h000);
		wr(8'hF9, 8'h55);
		cyc(2);
		chk(conv0_code, 12'hA55);
		wr(8'hFC, 8'h03);
		wr(8'hFB, 8'hC4);
		cyc(2);
		chk(conv1_code, 12'h3C4);
		wr(8'hFD, 8'h1B);
		wr(8'hF9, 8'h21);
		wr(8'hFB, 8'h43);
		cyc(2);
		chk({conv0_code, conv1_code}, {12'hA55, 12'h3C4});
		wr(8'hFD, 8'h1F);
		cyc(2);
		chk({conv0_code, conv1_code}, {12'hA21, 12'h343});
		wr(8'hFD, 8'h9F);
		wr(8'hF9, 8'hC3);
		cyc(2);
		chk(conv0_code, 12'h0C3);
		wr(8'hFD, 8'h67);
		cyc(2);
		chk(pins(), 6'h30);
		chk({conv0_code, conv1_code}, 24'h0);
		give_verdict;
	end
endmodule // ddc_top_bench
bind ddc_top ddc_properties ddc_props_u (.*);
